//--- inc/soc_cfg.svh
// constants for the supply output control block
`ifndef SOC_CFG_SVH
`define SOC_CFG_SVH

// register byte offsets
`define SOC_OFF_CTRL      8'h00
`define SOC_OFF_RCAUSE    8'h04
`define SOC_OFF_OTSTAT    8'h08
`define SOC_OFF_SUPSTAT   8'h0c
`define SOC_OFF_IRQSTAT   8'h10
`define SOC_OFF_IRQEN     8'h14
`define SOC_OFF_IRQCLR    8'h18

// bus widths and answers
`define SOC_ADDR_W        8
`define SOC_DATA_W        32
`define SOC_RESP_OKAY     2'b00
`define SOC_RESP_SLVERR   2'b10

// reset values
`define SOC_CTRL_RST      8'h00
`define SOC_IRQEN_RST     8'h00
`define SOC_IRQ_RST       8'h00
`define SOC_RCAUSE_RST    2'h0

// timing
`define SOC_CLK_PERIOD_NS 25
`define SOC_RST_PULSE_NS  1000000
`define SOC_RST_PULSE_CYC ((`SOC_RST_PULSE_NS + `SOC_CLK_PERIOD_NS - 1) / `SOC_CLK_PERIOD_NS)
`define SOC_CNT_W         16

// synchroniser
`define SOC_SYNC_W        9
`define SOC_SYNC_RST      9'h000

`endif

//--- inc/soc_pkg.sv
// types of the supply output control block
package soc_pkg;

  typedef enum logic [2:0]
  {
    SOC_MODE_SLEEP   = 3'b000,
    SOC_MODE_NREQ    = 3'b001,
    SOC_MODE_NORMAL  = 3'b010,
    SOC_MODE_STANDBY = 3'b011,
    SOC_MODE_EMERG   = 3'b100
  } soc_mode_e;

  typedef enum logic [2:0]
  {
    SOC_REG_CTRL    = 3'b000,
    SOC_REG_RCAUSE  = 3'b001,
    SOC_REG_OTSTAT  = 3'b010,
    SOC_REG_SUPSTAT = 3'b011,
    SOC_REG_IRQSTAT = 3'b100,
    SOC_REG_IRQEN   = 3'b101,
    SOC_REG_IRQCLR  = 3'b110,
    SOC_REG_NONE    = 3'b111
  } soc_reg_e;

  typedef struct packed {
    logic [2:0] spare;
    logic       bsw_cyclic;
    logic       bsw_sleep_on;
    logic       bsw_standby_on;
    logic       bsw_normal_on;
    logic       periph_req;
  } soc_ctrl_s;

  typedef struct packed {
    logic ext_rst;
    logic main_uv;
    logic bsw_ot;
    logic per_uv;
    logic per_sd;
    logic per_pre;
    logic main_sd;
    logic main_pre;
  } soc_irq_s;

  typedef struct packed {
    logic rst_pin;
    logic bat_present;
    logic main_uv;
    logic bsw_ot;
    logic per_uv;
    logic per_sd;
    logic per_pre;
    logic main_sd;
    logic main_pre;
  } soc_pins_s;

  typedef struct packed {
    logic ext_rst;
    logic main_uv;
  } soc_rcause_s;

  typedef struct packed {
    soc_ctrl_s         ctrl;
    soc_irq_s          irq_en;
    soc_irq_s          irq;
    soc_rcause_s       rcause;
    logic              main_sd_lat;
    logic              per_sd_lat;
    logic              bsw_ot_lat;
    soc_pins_s         prev;
    logic [15:0]       rst_cnt;
    logic              ext_low;
    logic [1:0]        oe_hist;
    logic              main_en;
    logic              per_en;
    logic              bsw_en;
    logic              rst_oe;
    logic              rst_lvl;
    logic              int_n;
    logic              normal_req;
    logic              awready;
    logic              wready;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        awaddr;
    logic [7:0]        wdata;
    logic              wstrb0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } soc_state_s;

endpackage

//--- inc/soc_sync_if.sv
// bundle between the top and its input synchroniser
`timescale 1ns/10ps
interface soc_sync_if #(parameter int W = 9);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  logic         rst_n;
  modport tgt  (input raw, output sync, output rst_n);
  modport user (output raw, input sync, input rst_n);
endinterface

//--- logic/soc_sync.sv
// reset release and two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`include "soc_cfg.svh"
module soc_sync #(
  parameter int W = `SOC_SYNC_W
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  soc_sync_if.tgt   sif
);
  import soc_pkg::*;

  typedef struct packed {
    logic [1:0]   rst_ff;
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } soc_sync_s;

  soc_sync_s sync_reg;
  soc_sync_s sync_next;

  //////////////////////////////////////////////////////////////////////////
  // first stage is read only by the second stage
  always_comb
  begin
    sync_next        = sync_reg;
    sync_next.rst_ff = {sync_reg.rst_ff[0], 1'b1};
    sync_next.s1     = sif.raw;
    sync_next.s2     = sync_reg.s1;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync_reg <= '{rst_ff: 2'b00, s1: W'(`SOC_SYNC_RST), s2: W'(`SOC_SYNC_RST)};
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  assign sif.sync  = sync_reg.s2;
  assign sif.rst_n = sync_reg.rst_ff[1];
endmodule

//--- logic/soc_top.sv
// supply output control: regulator enables, flags, reset pulse, register slave
`timescale 1ns/10ps
`include "soc_cfg.svh"

module soc_top #(
  parameter int RST_PULSE_CYC = `SOC_RST_PULSE_CYC
) (
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  input  wire soc_pkg::soc_mode_e       mode_i,
  input  wire logic                     cyc_on_i,
  input  wire logic                     main_pre_ot_i,
  input  wire logic                     main_sd_ot_i,
  input  wire logic                     per_pre_ot_i,
  input  wire logic                     per_sd_ot_i,
  input  wire logic                     per_uv_i,
  input  wire logic                     bsw_ot_i,
  input  wire logic                     main_uv_i,
  input  wire logic                     bat_present_i,
  input  wire logic                     rst_n_in_i,
  output logic                          rst_n_out_o,
  output logic                          rst_n_oe_o,
  output logic                          main_regulator_en_o,
  output logic                          peripheral_regulator_en_o,
  output logic                          battery_switch_en_o,
  output logic                          int_n_o,
  output logic                          normal_req_o,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [`SOC_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]               s_axi_awprot,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  input  wire logic [`SOC_DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  output logic [1:0]                    s_axi_bresp,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  input  wire logic [`SOC_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]               s_axi_arprot,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output logic [`SOC_DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                    s_axi_rresp
);
  import soc_pkg::*;

  localparam logic [`SOC_CNT_W-1:0] PULSE_LEN = `SOC_CNT_W'(RST_PULSE_CYC);

  soc_state_s st_reg;
  soc_state_s st_next;
  soc_pins_s  pin;
  logic       rst_n;

  //////////////////////////////////////////////////////////////////////////
  // synchronised pins and released reset
  soc_sync_if #(.W(`SOC_SYNC_W)) sif ();

  assign sif.raw = {rst_n_in_i, bat_present_i, main_uv_i, bsw_ot_i, per_uv_i,
                    per_sd_ot_i, per_pre_ot_i, main_sd_ot_i, main_pre_ot_i};
  assign pin     = soc_pins_s'(sif.sync);
  assign rst_n   = sif.rst_n;

  soc_sync #(
    .W      (`SOC_SYNC_W)
  ) u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .sif    (sif)
  );

  //////////////////////////////////////////////////////////////////////////
  // address decode shared by read and write
  function automatic soc_reg_e soc_decode(input logic [`SOC_ADDR_W-1:0] addr);
    logic [`SOC_ADDR_W-1:0] a;
    a = {addr[`SOC_ADDR_W-1:2], 2'b00};
    if (a == `SOC_OFF_CTRL)
      soc_decode = SOC_REG_CTRL;
    else if (a == `SOC_OFF_RCAUSE)
      soc_decode = SOC_REG_RCAUSE;
    else if (a == `SOC_OFF_OTSTAT)
      soc_decode = SOC_REG_OTSTAT;
    else if (a == `SOC_OFF_SUPSTAT)
      soc_decode = SOC_REG_SUPSTAT;
    else if (a == `SOC_OFF_IRQSTAT)
      soc_decode = SOC_REG_IRQSTAT;
    else if (a == `SOC_OFF_IRQEN)
      soc_decode = SOC_REG_IRQEN;
    else if (a == `SOC_OFF_IRQCLR)
      soc_decode = SOC_REG_IRQCLR;
    else
      soc_decode = SOC_REG_NONE;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    soc_irq_s    irq_set;
    soc_irq_s    irq_clr;
    soc_rcause_s rc_set;
    soc_rcause_s rc_clr;
    soc_reg_e    wsel;
    soc_reg_e    rsel;
    logic        do_wr;
    logic        per_reenable;
    logic        uv_edge;
    logic        main_mode_ok;
    logic        main_on;
    logic        per_on;
    logic        bsw_mode_on;
    logic        bsw_block;
    logic        drive;

    st_next      = st_reg;
    irq_set      = soc_irq_s'(`SOC_IRQ_RST);
    irq_clr      = soc_irq_s'(`SOC_IRQ_RST);
    rc_set       = soc_rcause_s'(`SOC_RCAUSE_RST);
    rc_clr       = soc_rcause_s'(`SOC_RCAUSE_RST);
    per_reenable = 1'b0;
    st_next.prev = pin;
    wsel         = SOC_REG_NONE;
    rsel         = SOC_REG_NONE;
    do_wr        = 1'b0;
    uv_edge      = 1'b0;
    main_mode_ok = 1'b0;
    main_on      = 1'b0;
    per_on       = 1'b0;
    bsw_mode_on  = 1'b0;
    bsw_block    = 1'b0;
    drive        = 1'b0;

    // write channel: address and data in either order
    if (s_axi_awvalid && st_reg.awready)
    begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready)
    begin
      st_next.w_got  = 1'b1;
      st_next.wdata  = s_axi_wdata[7:0];
      st_next.wstrb0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;

    wsel  = soc_decode(st_reg.awaddr);
    do_wr = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    if (do_wr)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = `SOC_RESP_OKAY;
      if (wsel == SOC_REG_CTRL)
      begin
        if (st_reg.wstrb0)
        begin
          st_next.ctrl = soc_ctrl_s'(st_reg.wdata);
          per_reenable = st_next.ctrl.periph_req;
        end
      end
      else if (wsel == SOC_REG_IRQEN)
      begin
        if (st_reg.wstrb0)
          st_next.irq_en = soc_irq_s'(st_reg.wdata);
      end
      else if (wsel == SOC_REG_IRQCLR)
      begin
        if (st_reg.wstrb0)
          irq_clr = soc_irq_s'(st_reg.wdata);
      end
      else if (wsel == SOC_REG_NONE)
        st_next.bresp = `SOC_RESP_SLVERR;
    end

    // read channel; reading the reset cause clears it
    if (s_axi_rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
    if (s_axi_arvalid && st_reg.arready)
    begin
      rsel           = soc_decode(s_axi_araddr);
      st_next.rvalid = 1'b1;
      st_next.rresp  = `SOC_RESP_OKAY;
      st_next.rdata  = '0;
      if (rsel == SOC_REG_CTRL)
        st_next.rdata = {24'h000000, st_reg.ctrl};
      else if (rsel == SOC_REG_RCAUSE)
      begin
        st_next.rdata = {30'h00000000, st_reg.rcause};
        rc_clr        = st_reg.rcause;
      end
      else if (rsel == SOC_REG_OTSTAT)
        st_next.rdata = {28'h0000000, pin.per_sd, pin.per_pre,
                         pin.main_sd, pin.main_pre};
      else if (rsel == SOC_REG_SUPSTAT)
        st_next.rdata = {26'h0000000, st_reg.per_sd_lat, st_reg.bsw_en, st_reg.per_en,
                         st_reg.main_en, pin.bsw_ot, pin.per_uv};
      else if (rsel == SOC_REG_IRQSTAT)
        st_next.rdata = {24'h000000, st_reg.irq};
      else if (rsel == SOC_REG_IRQEN)
        st_next.rdata = {24'h000000, st_reg.irq_en};
      else if (rsel == SOC_REG_IRQCLR)
        st_next.rdata = '0;
      else
        st_next.rresp = `SOC_RESP_SLVERR;
    end

    // events from the synchronised comparators
    uv_edge          = pin.main_uv ^ st_reg.prev.main_uv;
    irq_set.main_pre = pin.main_pre & ~st_reg.prev.main_pre;
    irq_set.main_sd  = pin.main_sd & ~st_reg.prev.main_sd;
    irq_set.per_pre  = pin.per_pre & ~st_reg.prev.per_pre;
    irq_set.per_sd   = pin.per_sd & ~st_reg.prev.per_sd;
    irq_set.per_uv   = pin.per_uv & ~st_reg.prev.per_uv;
    irq_set.bsw_ot   = pin.bsw_ot & ~st_reg.prev.bsw_ot;
    irq_set.main_uv  = uv_edge;

    // main regulator undervoltage: pulse counted from each edge
    if (uv_edge)
    begin
      st_next.rst_cnt = PULSE_LEN;
      rc_set.main_uv  = 1'b1;
    end
    else if (st_reg.rst_cnt != '0)
      st_next.rst_cnt = st_reg.rst_cnt - 1'b1;
    // stays in reset while the supply is low, as well
    drive = (st_next.rst_cnt != '0) || pin.main_uv;

    // external reset: only a low we did not cause counts;
    // the guard covers the sync delay after our own release
    st_next.oe_hist = {st_reg.oe_hist[0], st_reg.rst_oe};
    st_next.normal_req = 1'b0;
    if (!pin.rst_pin && !st_reg.rst_oe && (st_reg.oe_hist == 2'b00))
      st_next.ext_low = 1'b1;
    else if (pin.rst_pin && st_reg.ext_low)
    begin
      st_next.ext_low    = 1'b0;
      st_next.normal_req = 1'b1;
      irq_set.ext_rst    = 1'b1;
      rc_set.ext_rst     = 1'b1;
    end
    if (drive)
      st_next.ext_low = 1'b0;
    st_next.rst_oe  = drive;
    st_next.rst_lvl = !drive;

    // sticky flags: a set in the clearing cycle wins
    st_next.irq    = (st_reg.irq & ~irq_clr) | irq_set;
    st_next.rcause = (st_reg.rcause & ~rc_clr) | rc_set;

    // main regulator thermal latch, self-recovering
    if (pin.main_sd)
      st_next.main_sd_lat = 1'b1;
    else if (!pin.main_pre)
      st_next.main_sd_lat = 1'b0;

    main_mode_ok = (mode_i == SOC_MODE_NREQ) || (mode_i == SOC_MODE_NORMAL) ||
                   (mode_i == SOC_MODE_STANDBY);
    main_on = main_mode_ok && pin.bat_present && !st_next.main_sd_lat;

    // peripheral regulator latch needs software to release
    if (per_reenable && !pin.per_sd)
      st_next.per_sd_lat = 1'b0;
    if (pin.per_sd)
      st_next.per_sd_lat = 1'b1;

    per_on = (mode_i == SOC_MODE_NORMAL) && st_reg.ctrl.periph_req &&
             !st_next.per_sd_lat && !pin.per_sd;
    per_on = per_on && main_on;

    // battery switch
    if (pin.bsw_ot)
      st_next.bsw_ot_lat = 1'b1;
    else
      st_next.bsw_ot_lat = 1'b0;

    case (mode_i)
      SOC_MODE_NORMAL:  bsw_mode_on = st_reg.ctrl.bsw_normal_on;
      SOC_MODE_STANDBY: bsw_mode_on = st_reg.ctrl.bsw_standby_on;
      SOC_MODE_SLEEP:   bsw_mode_on = st_reg.ctrl.bsw_cyclic ? cyc_on_i
                                                             : st_reg.ctrl.bsw_sleep_on;
      default:          bsw_mode_on = 1'b0;
    endcase
    // sleep turns the main regulator off by design, so only a fault or emergency mode blocks here
    bsw_block = st_next.main_sd_lat || !pin.bat_present || (mode_i == SOC_MODE_EMERG) ||
                st_next.per_sd_lat;
    st_next.bsw_en  = bsw_mode_on && !bsw_block && !st_next.bsw_ot_lat;

    st_next.main_en = main_on;
    st_next.per_en  = per_on;

    // level interrupt pin, active low
    // one cycle behind flags and enables alike, so clear and unmask line up
    st_next.int_n = ~(|(st_reg.irq & st_reg.irq_en));

    // ready only when the channel is idle again
    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready  = !st_next.w_got && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg         <= '0;
      st_reg.ctrl    <= soc_ctrl_s'(`SOC_CTRL_RST);
      st_reg.irq_en  <= soc_irq_s'(`SOC_IRQEN_RST);
      st_reg.rst_lvl <= 1'b1;
      st_reg.int_n   <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign rst_n_out_o               = st_reg.rst_lvl;
  assign rst_n_oe_o                = st_reg.rst_oe;
  assign main_regulator_en_o       = st_reg.main_en;
  assign peripheral_regulator_en_o = st_reg.per_en;
  assign battery_switch_en_o       = st_reg.bsw_en;
  assign int_n_o                   = st_reg.int_n;
  assign normal_req_o              = st_reg.normal_req;
  assign s_axi_awready             = st_reg.awready;
  assign s_axi_wready              = st_reg.wready;
  assign s_axi_bvalid              = st_reg.bvalid;
  assign s_axi_bresp               = st_reg.bresp;
  assign s_axi_arready             = st_reg.arready;
  assign s_axi_rvalid              = st_reg.rvalid;
  assign s_axi_rdata               = st_reg.rdata;
  assign s_axi_rresp               = st_reg.rresp;
endmodule

//--- tb/soc_mcu_model.sv
// microcontroller side of the shared reset wire
`timescale 1ns/10ps
module soc_mcu_model (
  input  wire logic oe_i,
  input  wire logic out_i,
  input  wire logic hold_low_i,
  output logic      pin_o
);
  // wired low by either party, pulled up otherwise
  assign pin_o = !((oe_i && !out_i) || hold_low_i);
endmodule

//--- tb/soc_top_sva.sv
// concurrent checks on the supply output control ports
`timescale 1ns/10ps
module soc_top_sva #(
  parameter int RST_PULSE_CYC = 16
) (
  input wire logic               clk_i,
  input wire logic               nrst_i,
  input wire soc_pkg::soc_mode_e mode_i,
  input wire logic               main_sd_ot_i,
  input wire logic               per_sd_ot_i,
  input wire logic               bsw_ot_i,
  input wire logic               bat_present_i,
  input wire logic               rst_n_in_i,
  input wire logic               rst_n_out_o,
  input wire logic               rst_n_oe_o,
  input wire logic               main_regulator_en_o,
  input wire logic               peripheral_regulator_en_o,
  input wire logic               battery_switch_en_o,
  input wire logic               int_n_o,
  input wire logic               normal_req_o,
  input wire logic               s_axi_bvalid
);
  import soc_pkg::*;
  logic [15:0] oe_cnt;
  logic        wr_seen;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // run length of the reset drive; any write may unmask an interrupt
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i) oe_cnt <= 16'h0;
    else oe_cnt <= rst_n_oe_o ? oe_cnt + 16'h1 : 16'h0;
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i) wr_seen <= 1'b0;
    else wr_seen <= wr_seen | s_axi_bvalid;
  ////////////////////////////////////////////////////////////////////////////////
  a_main_mode: assert property (main_regulator_en_o |->
    $past(mode_i) inside {SOC_MODE_NREQ, SOC_MODE_NORMAL, SOC_MODE_STANDBY})
    else $error("main regulator on in wrong mode");
  a_per_mode: assert property (peripheral_regulator_en_o |->
    $past(mode_i) == SOC_MODE_NORMAL) else $error("peripheral on outside normal");
  a_bsw_nreq: assert property (battery_switch_en_o |->
    !($past(mode_i) inside {SOC_MODE_NREQ, SOC_MODE_EMERG})) else $error("switch on");
  a_bat_off: assert property (!bat_present_i [*5] |=>
    !main_regulator_en_o && !battery_switch_en_o) else $error("on without battery");
  a_main_sd: assert property (main_sd_ot_i [*5] |=> !main_regulator_en_o)
    else $error("main on during shut-off");
  a_per_sd: assert property (per_sd_ot_i [*5] |=>
    !peripheral_regulator_en_o && !battery_switch_en_o) else $error("on in shut-off");
  a_bsw_ot: assert property (bsw_ot_i [*5] |=> !battery_switch_en_o)
    else $error("switch on during overtemp");
  a_rst_drive: assert property (rst_n_oe_o |-> !rst_n_out_o)
    else $error("reset driven high");
  a_rst_len: assert property ($fell(rst_n_oe_o) |-> oe_cnt >= RST_PULSE_CYC)
    else $error("reset pulse short");
  a_nreq_pin: assert property (normal_req_o |->
    $past(rst_n_in_i, 3) && !$past(rst_n_in_i, 4)) else $error("request without release");
  a_nreq_pulse: assert property (normal_req_o |=> !normal_req_o)
    else $error("request longer than one cycle");
  a_int_hold: assert property (!int_n_o && !s_axi_bvalid |=> !int_n_o)
    else $error("interrupt released without write");
  a_int_gate: assert property ($fell(int_n_o) |-> wr_seen)
    else $error("interrupt with reset mask");
endmodule

bind soc_top soc_top_sva #(.RST_PULSE_CYC(RST_PULSE_CYC)) i_sva (.clk_i, .nrst_i, .mode_i,
  .main_sd_ot_i, .per_sd_ot_i, .bsw_ot_i, .bat_present_i, .rst_n_in_i, .rst_n_out_o,
  .rst_n_oe_o, .main_regulator_en_o, .peripheral_regulator_en_o, .battery_switch_en_o,
  .int_n_o, .normal_req_o, .s_axi_bvalid);

//--- tb/tb_top.sv
// self-checking bench for the supply output control block
`timescale 1ns/10ps
`include "soc_cfg.svh"
module tb_top;
  import soc_pkg::*;
  localparam int RPC = 16;
  logic        clk_i = 0, nrst_i = 0, cyc_on_i = 0, main_pre_ot_i = 0, main_sd_ot_i = 0;
  logic        per_pre_ot_i = 0, per_sd_ot_i = 0, per_uv_i = 0, bsw_ot_i = 0, main_uv_i = 0;
  logic        bat_present_i = 1, hold_low = 0, rst_n_in_i, rst_n_out_o, rst_n_oe_o;
  logic        main_regulator_en_o, peripheral_regulator_en_o, battery_switch_en_o;
  logic        int_n_o, normal_req_o, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic        s_axi_rready = 0, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, c;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  soc_mode_e   mode_i = SOC_MODE_NREQ;
  int          errors = 0, check_count = 0, seed = 32'h7dd9, n;
  wire  [2:0]  en = {main_regulator_en_o, peripheral_regulator_en_o, battery_switch_en_o};

  always #12.5 clk_i = ~clk_i;

  soc_top #(.RST_PULSE_CYC(RPC)) i_dut (.clk_i, .nrst_i, .mode_i, .cyc_on_i, .main_pre_ot_i,
    .main_sd_ot_i, .per_pre_ot_i, .per_sd_ot_i, .per_uv_i, .bsw_ot_i, .main_uv_i,
    .bat_present_i, .rst_n_in_i, .rst_n_out_o, .rst_n_oe_o, .main_regulator_en_o,
    .peripheral_regulator_en_o, .battery_switch_en_o, .int_n_o, .normal_req_o,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  soc_mcu_model i_mcu (.oe_i(rst_n_oe_o), .out_i(rst_n_out_o), .hold_low_i(hold_low),
    .pin_o(rst_n_in_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic check(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // bready is raised with the request; the wait ends on the response
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge clk_i);
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_bready <= 1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk_i);
    s_axi_arvalid <= 1;
    s_axi_araddr <= a;
    s_axi_rready <= 1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // expected {main, peripheral, switch} with no thermal condition
  function automatic logic [2:0] exp_en(input soc_mode_e m, input logic [7:0] k,
                                        input logic b, input logic cy);
    logic mn, sw;
    mn = (m inside {SOC_MODE_NREQ, SOC_MODE_NORMAL, SOC_MODE_STANDBY}) && b;
    case (m)
      SOC_MODE_NORMAL:  sw = k[1];
      SOC_MODE_STANDBY: sw = k[2];
      SOC_MODE_SLEEP:   sw = k[4] ? cy : k[3];
      default:          sw = 1'b0;
    endcase
    return {mn, mn && m == SOC_MODE_NORMAL && k[0], sw && b};
  endfunction
  task automatic final_report();
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(25 * 20000);
    errors++;
    final_report();
  end

  initial
  begin
    cyc(20);
    nrst_i <= 1;
    cyc(4);
    wr(`SOC_OFF_CTRL, 32'h03, r);
    mode_i <= SOC_MODE_NORMAL;
    cyc(5);
    check(en === 3'b111, "all on in normal");
    per_sd_ot_i <= 1;
    cyc(6);
    check(en === 3'b100, "peripheral shut-off");
    per_sd_ot_i <= 0;
    cyc(6);
    check(en === 3'b100, "peripheral stays off");
    wr(`SOC_OFF_CTRL, 32'h03, r);
    cyc(3);
    check(en === 3'b111, "peripheral released");
    main_pre_ot_i <= 1;
    main_sd_ot_i <= 1;
    cyc(6);
    check(en[2:1] === 2'b00, "main shut-off");
    rd(`SOC_OFF_OTSTAT, d, r);
    check(d[1:0] === 2'b11, "main temp flags");
    main_sd_ot_i <= 0;
    cyc(6);
    check(en[2] === 1'b0, "main waits for pre-warning");
    main_pre_ot_i <= 0;
    cyc(6);
    check(en[2] === 1'b1, "main back on");
    bsw_ot_i <= 1;
    per_uv_i <= 1;
    cyc(6);
    check(en[0] === 1'b0, "switch overtemp off");
    rd(`SOC_OFF_SUPSTAT, d, r);
    check(d[1:0] === 2'b11, "supply flags");
    bsw_ot_i <= 0;
    per_uv_i <= 0;
    cyc(6);
    check(en[0] === 1'b1, "switch recovers");
    rd(`SOC_OFF_IRQSTAT, d, r);
    check(d[7:0] === 8'h3b, "flags despite mask");
    check(int_n_o === 1'b1, "masked interrupt");
    wr(`SOC_OFF_IRQCLR, 32'hff, r);
    wr(`SOC_OFF_IRQEN, 32'h04, r);
    per_pre_ot_i <= 1;
    cyc(6);
    check(int_n_o === 1'b0, "enabled interrupt");
    wr(`SOC_OFF_IRQEN, 32'h00, r);
    cyc(2);
    check(int_n_o === 1'b1, "mask gates pin");
    wr(`SOC_OFF_IRQEN, 32'h04, r);
    cyc(2);
    check(int_n_o === 1'b0, "pending until cleared");
    wr(`SOC_OFF_IRQCLR, 32'h04, r);
    cyc(2);
    check(int_n_o === 1'b1, "cleared");
    per_pre_ot_i <= 0;
    main_uv_i <= 1;
    cyc(4);
    main_uv_i <= 0;
    n = 0;
    repeat (40)
    begin
      @(posedge clk_i);
      if (rst_n_oe_o === 1'b1) n++;
    end
    check(n >= RPC && n <= RPC + 6, "reset pulse length");
    rd(`SOC_OFF_RCAUSE, d, r);
    check(d[0] === 1'b1, "undervoltage cause");
    rd(`SOC_OFF_RCAUSE, d, r);
    check(d[0] === 1'b0, "cause cleared on read");
    hold_low <= 1;
    cyc(5);
    hold_low <= 0;
    n = 0;
    repeat (8)
    begin
      @(posedge clk_i);
      if (normal_req_o === 1'b1) n++;
    end
    check(n == 1, "request after release");
    rd(`SOC_OFF_IRQSTAT, d, r);
    check(d[7] === 1'b1, "external reset flag");
    rd(8'h1c, d, r);
    check(r === `SOC_RESP_SLVERR && d === 32'h0, "unmapped read");
    wr(8'h20, 32'h0, r);
    check(r === `SOC_RESP_SLVERR, "unmapped write");
    repeat (30)
    begin
      d = $random(seed);
      c = d[7:0];
      wr(`SOC_OFF_CTRL, {24'h0, c}, r);
      mode_i <= soc_mode_e'(3'(d[15:8] % 5));
      cyc_on_i <= d[16];
      bat_present_i <= d[17] | d[18];
      cyc(5);
      check(en === exp_en(mode_i, c, bat_present_i, cyc_on_i), "mode table");
    end
    // byte lane 0 off: the configuration must stay as written last
    s_axi_wstrb <= 4'h0;
    wr(`SOC_OFF_CTRL, 32'h0, r);
    s_axi_wstrb <= 4'hf;
    rd(`SOC_OFF_CTRL, d, r);
    check(d === {24'h0, c} && r === `SOC_RESP_OKAY, "masked write kept");
    final_report();
  end
endmodule
